// [rtl/ckg_pkg.sv]
// Operation
// - Low-speed oscillator runs after reset release until stopped while on high-speed.
// - Reset clears CPU clock select to low-speed.
// - CPU clock withheld for 17 low-speed cycles.
// - Both oscillators stopped while reset is asserted.
// - Read-only status shows the clock driving CPU.
// - STOP release on high-speed waits selected count with resonator source only.
// - Prescaler divides whichever clock the status shows.
// - High-speed source fixed by build option.
// - Internal source frees second pin as input.
// - Status reads 0 on low-speed, 1 on high-speed.
// - Stabilization flags set in order; STOP entry or high-speed stop clears them.
package ckg_pkg;

  // ---------------------------------------------------------------------------
  // High-speed source options
  // ---------------------------------------------------------------------------
  localparam logic [1:0] CKG_SRC_RESONATOR = 2'h0;
  localparam logic [1:0] CKG_SRC_EXT_RC = 2'h1;
  localparam logic [1:0] CKG_SRC_INTERNAL = 2'h2;

  // ---------------------------------------------------------------------------
  // Field positions, reset values and counts
  // ---------------------------------------------------------------------------
  localparam int CKG_SELECT_BIT = 0;
  localparam int CKG_STATUS_BIT = 1;
  localparam logic CKG_SELECT_RESET = 1'h0;
  localparam logic [2:0] CKG_WAIT_SEL_RESET = 3'h5;
  localparam logic [4:0] CKG_START_CYCLES = 5'h11;
  localparam int CKG_STAB_BITS = 5;
  localparam int CKG_CNT_W = 17;

  // Thresholds in high-speed periods, first flag (bit 4) reaches 2^11 first.
  localparam logic [16:0] CKG_TH_11 = 17'h00800;
  localparam logic [16:0] CKG_TH_13 = 17'h02000;
  localparam logic [16:0] CKG_TH_14 = 17'h04000;
  localparam logic [16:0] CKG_TH_15 = 17'h08000;
  localparam logic [16:0] CKG_TH_16 = 17'h10000;

  localparam logic [2:0] CKG_WSEL_11 = 3'h1;
  localparam logic [2:0] CKG_WSEL_13 = 3'h2;
  localparam logic [2:0] CKG_WSEL_14 = 3'h3;
  localparam logic [2:0] CKG_WSEL_15 = 3'h4;

endpackage : ckg_pkg

// [rtl/ckg_prescaler.sv]
`timescale 1ns/1ps
module ckg_prescaler
  import ckg_pkg::*;
#(
  parameter int DIV_W = 5
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Source clock edges and gating
  input wire logic src_tick_in,
  input wire logic run_in,
  // Divided edges
  output logic cpu_tick_out,
  output logic [DIV_W-1:0] periph_tick_out
);

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic cpu_tick;
    logic [DIV_W-1:0] periph;
  } ckg_div_t;

  ckg_div_t st;
  ckg_div_t next_st;
  logic [DIV_W-1:0] all_ones;

  // Output k fires once every 2^k source edges.
  genvar g;
  generate
    for (g = 0; g < DIV_W; g++) begin : g_mask
      if (g == 0) begin : g_first
        assign all_ones[g] = 1'b1;
      end else begin : g_rest
        assign all_ones[g] = &st.cnt[g-1:0];
      end
    end
  endgenerate

  always_comb begin
    next_st = st;
    next_st.cpu_tick = src_tick_in && run_in;
    next_st.periph = '0;
    if (src_tick_in && run_in) begin
      next_st.cnt = st.cnt + 1'b1;
      next_st.periph = all_ones;
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign cpu_tick_out = st.cpu_tick;
  assign periph_tick_out = st.periph;

endmodule : ckg_prescaler

// [rtl/ckg_clock_gen.sv]
`timescale 1ns/1ps
module ckg_clock_gen
  import ckg_pkg::*;
#(
  parameter logic [1:0] HS_SOURCE = CKG_SRC_RESONATOR,
  parameter logic LS_STOPPABLE = 1'b1,
  parameter int DIV_W = 5
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Oscillator edges, one-cycle pulses, only meaningful while running
  input wire logic ls_tick_in,
  input wire logic hs_tick_in,
  // Clock mode control writes
  input wire logic mode_wr_in,
  input wire logic cpu_clock_select_in,
  // Oscillator control writes
  input wire logic lso_wr_in,
  input wire logic low_speed_osc_stop_in,
  input wire logic hso_wr_in,
  input wire logic high_speed_osc_stop_in,
  input wire logic wait_sel_wr_in,
  input wire logic [2:0] stabilization_wait_select_in,
  // Standby control, one-cycle pulses
  input wire logic stop_enter_in,
  input wire logic stop_release_in,
  // Second oscillator pin level
  input wire logic osc_pin2_in,
  // Oscillator enables
  output logic ls_osc_run_out,
  output logic hs_osc_run_out,
  // Clock mode control and status
  output logic cpu_clock_select_out,
  output logic cpu_clock_status_out,
  output logic low_speed_osc_control_out,
  output logic high_speed_osc_control_out,
  output logic [2:0] stabilization_wait_select_out,
  output logic [CKG_STAB_BITS-1:0] stabilization_counter_status_out,
  output logic cpu_running_out,
  // Clock edges
  output logic cpu_tick_out,
  output logic [DIV_W-1:0] periph_tick_out,
  // Spare input pin
  output logic spare_input_port_pin_out,
  output logic spare_input_valid_out
);

  typedef struct packed {
    logic ls_run;
    logic hs_run;
    logic cpu_run;
    logic start_done;
    logic [4:0] start_cnt;
    logic sel;
    logic status;
    logic arm;
    logic lso_stop;
    logic hso_stop;
    logic [2:0] wait_sel;
    logic [CKG_CNT_W-1:0] stab_cnt;
    logic [CKG_STAB_BITS-1:0] stab_flags;
    logic stop_active;
    logic stop_wait;
    logic cap;
    logic spare_pin;
    logic spare_valid;
  } ckg_state_t;

  localparam logic [CKG_CNT_W-1:0] TH [CKG_STAB_BITS] =
    '{CKG_TH_16, CKG_TH_15, CKG_TH_14, CKG_TH_13, CKG_TH_11};

  ckg_state_t st;
  ckg_state_t next_st;
  logic src_tick;

  // ---------------------------------------------------------------------------
  // Wait limit decode
  // ---------------------------------------------------------------------------
  // Prohibited codes fall back to the longest wait so the CPU never starts early.
  function automatic logic [CKG_CNT_W-1:0] wait_limit(input logic [2:0] code);
    case (code)
      CKG_WSEL_11: wait_limit = CKG_TH_11;
      CKG_WSEL_13: wait_limit = CKG_TH_13;
      CKG_WSEL_14: wait_limit = CKG_TH_14;
      CKG_WSEL_15: wait_limit = CKG_TH_15;
      default: wait_limit = CKG_TH_16;
    endcase
  endfunction : wait_limit

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb begin
    logic cur_tick;
    logic tgt_tick;
    logic [CKG_CNT_W-1:0] lim;
    cur_tick = 1'b0;
    tgt_tick = 1'b0;
    lim = wait_limit(st.wait_sel);
    next_st = st;

    // Register writes from software.
    if (mode_wr_in) begin
      next_st.sel = cpu_clock_select_in;
    end
    if (lso_wr_in) begin
      next_st.lso_stop = low_speed_osc_stop_in;
    end
    if (hso_wr_in) begin
      next_st.hso_stop = high_speed_osc_stop_in;
    end
    if (wait_sel_wr_in) begin
      next_st.wait_sel = stabilization_wait_select_in;
    end

    // Low-speed stop takes effect only when stoppable and on high-speed.
    next_st.ls_run = !(LS_STOPPABLE && st.lso_stop && st.status);

    // Start-up hold after reset release.
    if (!st.start_done && st.ls_run && ls_tick_in) begin
      next_st.start_cnt = st.start_cnt + 1'b1;
      if (st.start_cnt == CKG_START_CYCLES - 5'h01) begin
        next_st.start_done = 1'b1;
        next_st.cpu_run = 1'b1;
      end
    end

    // Clock switch: one edge of the old clock, then one of the new.
    cur_tick = st.status ? hs_tick_in : ls_tick_in;
    tgt_tick = st.status ? ls_tick_in : hs_tick_in;
    if (st.sel == st.status || st.stop_active || !st.start_done) begin
      next_st.arm = 1'b0;
    end else if (!st.arm) begin
      next_st.arm = cur_tick;
    end else if (tgt_tick) begin
      next_st.status = st.sel;
      next_st.arm = 1'b0;
    end

    // Stabilization counter, saturating; capped at the wait after STOP release.
    if (st.hs_run && hs_tick_in && st.stab_cnt < CKG_TH_16 && !(st.cap && st.stab_cnt >= lim)) begin
      next_st.stab_cnt = st.stab_cnt + 1'b1;
    end
    for (int i = 0; i < CKG_STAB_BITS; i++) begin
      if (st.stab_cnt >= TH[i]) begin
        next_st.stab_flags[i] = 1'b1;
      end
    end

    // STOP entry halts the CPU and restarts stabilization counting.
    if (stop_enter_in && !st.stop_active && st.cpu_run) begin
      next_st.stop_active = 1'b1;
      next_st.cpu_run = 1'b0;
      next_st.stab_cnt = '0;
      next_st.stab_flags = '0;
      next_st.cap = 1'b0;
    end else if (stop_release_in && st.stop_active) begin
      next_st.stop_active = 1'b0;
      next_st.cap = 1'b1;
      if (st.status && HS_SOURCE == CKG_SRC_RESONATOR) begin
        next_st.stop_wait = 1'b1;
      end else begin
        next_st.cpu_run = 1'b1;
      end
    end else if (st.stop_wait && st.stab_cnt >= lim) begin
      next_st.stop_wait = 1'b0;
      next_st.cpu_run = 1'b1;
    end

    // High-speed stop takes effect only while on low-speed. STOP gates the oscillator on the
    // same edge as the CPU, so no stray tick reaches the counter and a CPU resumed without a
    // wait never runs while the fast oscillator is still held off.
    next_st.hs_run = !(st.hso_stop && !st.status) && !next_st.stop_active;

    // A high-speed stop clears the status bits as well.
    if (next_st.hso_stop && !st.status) begin
      next_st.stab_cnt = '0;
      next_st.stab_flags = '0;
    end

    // The second pin is a plain input only with the internal source.
    next_st.spare_valid = (HS_SOURCE == CKG_SRC_INTERNAL);
    next_st.spare_pin = (HS_SOURCE == CKG_SRC_INTERNAL) && osc_pin2_in;
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st <= '0;
      st.sel <= CKG_SELECT_RESET;
      st.wait_sel <= CKG_WAIT_SEL_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------------------
  // Prescaler on the clock shown by status
  // ---------------------------------------------------------------------------
  assign src_tick = st.status ? (hs_tick_in && st.hs_run) : (ls_tick_in && st.ls_run);

  ckg_prescaler #(
    .DIV_W(DIV_W)
  ) u_prescaler (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .src_tick_in(src_tick),
    .run_in(st.cpu_run),
    .cpu_tick_out(cpu_tick_out),
    .periph_tick_out(periph_tick_out)
  );

  assign ls_osc_run_out = st.ls_run;
  assign hs_osc_run_out = st.hs_run;
  assign cpu_clock_select_out = st.sel;
  assign cpu_clock_status_out = st.status;
  assign low_speed_osc_control_out = st.lso_stop;
  assign high_speed_osc_control_out = st.hso_stop;
  assign stabilization_wait_select_out = st.wait_sel;
  assign stabilization_counter_status_out = st.stab_flags;
  assign cpu_running_out = st.cpu_run;
  assign spare_input_port_pin_out = st.spare_pin;
  assign spare_input_valid_out = st.spare_valid;

endmodule : ckg_clock_gen

// [testbench/ckg_clock_gen_checker.sv]
`timescale 1ns/1ps
module ckg_checker (
  // Watched ports
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic ls_tick_in,
  input wire logic hs_tick_in,
  input wire logic mode_wr_in,
  input wire logic cpu_clock_select_in,
  input wire logic stop_enter_in,
  input wire logic ls_osc_run_out,
  input wire logic hs_osc_run_out,
  input wire logic cpu_clock_select_out,
  input wire logic cpu_clock_status_out,
  input wire logic [4:0] stabilization_counter_status_out,
  input wire logic cpu_running_out,
  input wire logic cpu_tick_out
);
  logic [4:0] cnt;
  logic started;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  // ---------------------------------------------------------------------------
  // Start-up tick count, saturating so a long run never wraps.
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cnt <= 5'h00;
      started <= 1'b0;
    end else begin
      if (ls_tick_in && ls_osc_run_out && cnt != 5'h1F) cnt <= cnt + 5'h01;
      if (cpu_running_out) started <= 1'b1;
    end
  end
  sequence s_ls_edge;
    cpu_running_out && !cpu_clock_status_out && ls_tick_in && !hs_tick_in && !stop_enter_in;
  endsequence
  sequence s_stop_taken;
    stop_enter_in && cpu_running_out;
  endsequence
  property p_start; !started |-> (cpu_running_out == (cnt >= 5'h11)); endproperty
  a_start: assert property (p_start) else $error("cpu start count wrong");
  property p_sel; mode_wr_in |=> cpu_clock_select_out == $past(cpu_clock_select_in); endproperty
  a_sel: assert property (p_sel) else $error("select write lost");
  property p_rise; $rose(cpu_clock_status_out) |-> $past(hs_tick_in); endproperty
  a_rise: assert property (p_rise) else $error("status rose without fast edge");
  property p_fall; $fell(cpu_clock_status_out) |-> $past(ls_tick_in); endproperty
  a_fall: assert property (p_fall) else $error("status fell without slow edge");
  property p_ls_tick; s_ls_edge |=> cpu_tick_out; endproperty
  a_ls_tick: assert property (p_ls_tick) else $error("slow edge not passed to cpu");
  property p_thermo;
    stabilization_counter_status_out inside {5'h00, 5'h10, 5'h18, 5'h1C, 5'h1E, 5'h1F};
  endproperty
  a_thermo: assert property (p_thermo) else $error("flags out of order");
  property p_hs_run; cpu_running_out && cpu_clock_status_out |-> hs_osc_run_out; endproperty
  a_hs_run: assert property (p_hs_run) else $error("fast osc off while in use");
  property p_ls_run; cpu_running_out && !cpu_clock_status_out |-> ls_osc_run_out; endproperty
  a_ls_run: assert property (p_ls_run) else $error("slow osc off while in use");
  property p_stop;
    s_stop_taken |=> !cpu_running_out ##1 (!hs_osc_run_out && stabilization_counter_status_out == 5'h00);
  endproperty
  a_stop: assert property (p_stop) else $error("stop entry wrong");
endmodule : ckg_checker
bind ckg_clock_gen ckg_checker u_ckg_checker (
  .clk_in(clk_in),
  .sys_rst_in(sys_rst_in),
  .ls_tick_in(ls_tick_in),
  .hs_tick_in(hs_tick_in),
  .mode_wr_in(mode_wr_in),
  .cpu_clock_select_in(cpu_clock_select_in),
  .stop_enter_in(stop_enter_in),
  .ls_osc_run_out(ls_osc_run_out),
  .hs_osc_run_out(hs_osc_run_out),
  .cpu_clock_select_out(cpu_clock_select_out),
  .cpu_clock_status_out(cpu_clock_status_out),
  .stabilization_counter_status_out(stabilization_counter_status_out),
  .cpu_running_out(cpu_running_out),
  .cpu_tick_out(cpu_tick_out)
);

// [testbench/tb.sv]
`timescale 1ns/1ps
module tb;
  import ckg_pkg::*;
  logic clk_in = 1'b0, sys_rst_in = 1'b1, ls_tick_in = 1'b0, hs_tick_in = 1'b0;
  logic mode_wr_in = 1'b0, cpu_clock_select_in = 1'b0, lso_wr_in = 1'b0;
  logic low_speed_osc_stop_in = 1'b0, hso_wr_in = 1'b0, high_speed_osc_stop_in = 1'b0;
  logic wait_sel_wr_in = 1'b0, stop_enter_in = 1'b0, stop_release_in = 1'b0;
  logic osc_pin2_in = 1'b0;
  logic [2:0] stabilization_wait_select_in = 3'h5;
  logic ls_osc_run_out, hs_osc_run_out, cpu_clock_select_out, cpu_clock_status_out;
  logic low_speed_osc_control_out, high_speed_osc_control_out, cpu_running_out, cpu_tick_out;
  logic spare_input_port_pin_out, spare_input_valid_out;
  logic [2:0] stabilization_wait_select_out;
  logic [4:0] stabilization_counter_status_out, periph_tick_out;
  int n_fail = 0, total_checks = 0;
  int th[5] = '{32'h800, 32'h2000, 32'h4000, 32'h8000, 32'h10000};
  logic [4:0] fl[6] = '{5'h00, 5'h10, 5'h18, 5'h1C, 5'h1E, 5'h1F};
  always #12.5 clk_in = ~clk_in;
  ckg_clock_gen u_ckg_clock_gen (.clk_in, .sys_rst_in, .ls_tick_in, .hs_tick_in, .mode_wr_in,
    .cpu_clock_select_in, .lso_wr_in, .low_speed_osc_stop_in, .hso_wr_in,
    .high_speed_osc_stop_in, .wait_sel_wr_in, .stabilization_wait_select_in, .stop_enter_in,
    .stop_release_in, .osc_pin2_in, .ls_osc_run_out, .hs_osc_run_out,
    .cpu_clock_select_out, .cpu_clock_status_out, .low_speed_osc_control_out,
    .high_speed_osc_control_out, .stabilization_wait_select_out,
    .stabilization_counter_status_out, .cpu_running_out, .cpu_tick_out, .periph_tick_out,
    .spare_input_port_pin_out, .spare_input_valid_out);
  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic cyc(input int n); repeat (n) @(negedge clk_in); endtask : cyc
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic ls_pulse(input int n);
    repeat (n) begin
      ls_tick_in = 1'b1;
      cyc(1);
      ls_tick_in = 1'b0;
      cyc(1);
    end
  endtask : ls_pulse
  // One STOP entry and release; the caller judges what follows the release.
  task automatic stop_cycle;
    stop_enter_in = 1'b1;
    cyc(1);
    stop_enter_in = 1'b0;
    cyc(2);
    chk(8'(cpu_running_out), 8'h00);
    chk(8'(hs_osc_run_out), 8'h00);
    chk(8'(stabilization_counter_status_out), 8'h00);
    stop_release_in = 1'b1;
    cyc(1);
    stop_release_in = 1'b0;
  endtask : stop_cycle
  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_reset;
    cyc(2);
    chk(8'(ls_osc_run_out), 8'h00);
    chk(8'(hs_osc_run_out), 8'h00);
    chk(8'(cpu_clock_select_out), 8'h00);
    chk(8'(cpu_clock_status_out), 8'h00);
    chk(8'(cpu_running_out), 8'h00);
    chk(8'(stabilization_wait_select_out), 8'(CKG_WAIT_SEL_RESET));
    cyc(1);
    sys_rst_in = 1'b0;
    cyc(1);
    chk(8'(ls_osc_run_out), 8'h01);
  endtask : t_reset
  task automatic t_start;
    ls_pulse(16);
    chk(8'(cpu_running_out), 8'h00);
    ls_pulse(1);
    chk(8'(cpu_running_out), 8'h01);
    ls_tick_in = 1'b1;
    cyc(1);
    ls_tick_in = 1'b0;
    chk(8'(cpu_tick_out), 8'h01);
    chk(8'(periph_tick_out), 8'h01);
    cyc(1);
    chk(8'(cpu_tick_out), 8'h00);
    ls_tick_in = 1'b1;
    cyc(1);
    ls_tick_in = 1'b0;
    chk(8'(periph_tick_out), 8'h03);
  endtask : t_start
  // Fast edges run every cycle from here on, so tick counts equal clock counts.
  task automatic t_stab;
    int el;
    el = 0;
    hs_tick_in = 1'b1;
    for (int i = 0; i < 5; i++) begin
      cyc(th[i] - 1 - el);
      chk(8'(stabilization_counter_status_out), 8'(fl[i]));
      cyc(3);
      el = th[i] + 2;
      chk(8'(stabilization_counter_status_out), 8'(fl[i+1]));
    end
  endtask : t_stab
  // Two slow edges: the first arms a switch to fast, the second ends a switch to slow.
  task automatic t_switch(input logic to_hs);
    mode_wr_in = 1'b1;
    cpu_clock_select_in = to_hs;
    cyc(1);
    mode_wr_in = 1'b0;
    chk(8'(cpu_clock_select_out), 8'(to_hs));
    chk(8'(cpu_clock_status_out), 8'(!to_hs));
    ls_pulse(2);
    cyc(2);
    chk(8'(cpu_clock_status_out), 8'(to_hs));
    chk(8'(cpu_tick_out), 8'(to_hs));
  endtask : t_switch
  task automatic t_osc(input logic ls_stop, input logic hs_stop, input logic ls_on,
                       input logic hs_on);
    lso_wr_in = 1'b1;
    low_speed_osc_stop_in = ls_stop;
    hso_wr_in = 1'b1;
    high_speed_osc_stop_in = hs_stop;
    cyc(1);
    lso_wr_in = 1'b0;
    hso_wr_in = 1'b0;
    chk(8'(low_speed_osc_control_out), 8'(ls_stop));
    chk(8'(high_speed_osc_control_out), 8'(hs_stop));
    cyc(1);
    chk(8'(ls_osc_run_out), 8'(ls_on));
    chk(8'(hs_osc_run_out), 8'(hs_on));
    if (hs_stop) begin
      chk(8'(stabilization_counter_status_out), 8'h00);
    end
  endtask : t_osc
  task automatic t_stop;
    wait_sel_wr_in = 1'b1;
    stabilization_wait_select_in = CKG_WSEL_11;
    cyc(1);
    wait_sel_wr_in = 1'b0;
    chk(8'(stabilization_wait_select_out), 8'(CKG_WSEL_11));
    stop_cycle();
    cyc(2048);
    chk(8'(cpu_running_out), 8'h00);
    cyc(1);
    chk(8'(cpu_running_out), 8'h01);
    chk(8'(stabilization_counter_status_out), 8'h10);
  endtask : t_stop
  // On the slow clock the CPU resumes at once and software polls the status itself.
  task automatic t_stop_ls;
    stop_cycle();
    chk(8'(cpu_running_out), 8'h01);
    cyc(2048);
    chk(8'(stabilization_counter_status_out), 8'h00);
    cyc(1);
    chk(8'(stabilization_counter_status_out), 8'h10);
  endtask : t_stop_ls
  task automatic t_spare;
    osc_pin2_in = 1'b1;
    cyc(2);
    chk(8'(spare_input_port_pin_out), 8'h00);
    chk(8'(spare_input_valid_out), 8'h00);
  endtask : t_spare
  task automatic end_sim;
    if (n_fail == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim
  initial begin
    cyc(1);
    t_reset();
    t_start();
    t_stab();
    t_switch(1'b1);
    t_osc(1'b1, 1'b0, 1'b0, 1'b1);
    t_osc(1'b0, 1'b0, 1'b1, 1'b1);
    t_stop();
    t_switch(1'b0);
    t_stop_ls();
    t_osc(1'b0, 1'b1, 1'b1, 1'b0);
    t_spare();
    end_sim();
  end
  initial begin
    #2500000;
    n_fail++;
    end_sim();
  end
endmodule : tb
